/* File: uart_lin_receive_and_break.sv */
/*
  receive path of an asynchronous serial port with lin break send and
  break receive, error status, noise filter and a small receive queue.
  assumes clk_i is the base clock and all inputs are synchronous to it.
*/
// Notes on behaviour
// - reception samples the pin only with power and receive enable both set
// - falling edge starts counter; after divisor counts a low level is start
// - shift data at baud rate; at stop raise complete irq and store data
// - on overrun the new data is dropped and the old buffer stays
// - parity error waits for the stop position before the error irq
// - only one stop bit is checked; a second one is ignored
// - flag parity mismatch in odd and even modes only, missing stop bit, and frame ending with the receive queue full
// - error status holds overrun, parity, framing in bits 0 to 2
// - with merge bit 0, any error flag set by a frame raises the error irq
// - reading the error status clears it to zero, except an error set by a frame in the same cycle
// - merge bit 0 gives a separate error irq, 1 uses the complete irq
// - pin filtered by two agreeing base clock samples, three clocks of lag
// - power drives the transmit pin high; break trigger starts a break
// - break drives the pin low 13 to 20 bit times per length field
// - break end raises transmit complete and clears the trigger itself
// - break receive enable uses normal start bit detection
// - low of 11 bits or more: complete irq, clear break flag and enable
// - break receive suppresses error flags and never loads the buffer
// - low of 10 bits or less: no irq, break receive stays armed
// - separate 9-bit divisor counters for transmit and receive
// - bit time is twice the divisor in base clocks, divisor 4 to 255
// - receive counter cleared while disabled, runs one frame per start
`timescale 1ns/1ns
module uart_lin_receive_and_break #(
  parameter int FIFO_DEPTH = uart_lin_rx_pkg::FIFO_DEPTH
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire uart_lin_rx_pkg::serial_mode_t mode_i,
  input  wire logic                          break_tx_set_i,
  input  wire logic                          break_rx_enable_set_i,
  input  wire logic                          rx_status_read_i,
  input  wire logic                          rx_buffer_read_i,
  input  wire logic                          serial_in_pin_i,
  output logic                               serial_out_pin_o,
  output logic [7:0]                         receive_buffer_reg_o,
  output logic                               rx_buffer_valid_o,
  output uart_lin_rx_pkg::rx_err_t           rx_error_status_reg_o,
  output logic                               rx_complete_irq_o,
  output logic                               rx_error_irq_o,
  output logic                               tx_complete_irq_o,
  output logic                               break_tx_trigger_o,
  output logic                               break_rx_enable_o,
  output logic                               break_rx_flag_o
);
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_BREAK
  } rx_state_t;

  if (FIFO_DEPTH < 2) begin : g_fifo_chk
    $error("receive queue needs at least two words");
  end

  localparam int CW = uart_lin_rx_pkg::CNT_W;

  // noise filter
  logic samp0_q;
  logic samp1_q;
  logic filt_q;
  logic filt_prev_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp0_q     <= 1'b1;
      samp1_q     <= 1'b1;
      filt_q      <= 1'b1;
      filt_prev_q <= 1'b1;
    end else begin
      samp0_q     <= serial_in_pin_i;
      samp1_q     <= samp0_q;
      filt_prev_q <= filt_q;
      if (samp0_q == samp1_q) begin
        filt_q <= samp0_q;
      end
    end
  end

  // baud limits: half bit and full bit in base clocks
  logic [7:0]    div_eff;
  logic [CW-1:0] half_lim;
  logic [CW-1:0] full_lim;

  assign div_eff = (mode_i.baud_divisor_field < uart_lin_rx_pkg::DIV_MIN)
                   ? uart_lin_rx_pkg::DIV_MIN : mode_i.baud_divisor_field;
  assign half_lim = {1'b0, div_eff} - 9'h001;
  assign full_lim = {div_eff, 1'b0} - 9'h001;

  // receive sequencer
  logic          rx_on;
  rx_state_t     rx_state_q;
  logic [CW-1:0] rx_cnt_q;
  logic [2:0]    bit_idx_q;
  logic [7:0]    shift_q;
  logic          par_bit_q;
  logic [4:0]    low_cnt_q;
  logic          bit_tick;
  logic          start_tick;
  logic          frame_end;
  logic          brk_end;
  logic          brk_ok;
  logic          data_par;
  uart_lin_rx_pkg::rx_err_t new_err;
  logic          fifo_in_ready;
  logic          fifo_push;
  logic          brk_rx_en_q;

  assign rx_on      = mode_i.port_power_on && mode_i.receive_enable_bit;
  assign start_tick = (rx_state_q == RX_START) && (rx_cnt_q == half_lim);
  assign bit_tick   = (rx_cnt_q == full_lim);
  assign frame_end  = (rx_state_q == RX_STOP) && bit_tick;
  assign brk_end    = (rx_state_q == RX_BREAK) && bit_tick && filt_q;
  assign brk_ok     = low_cnt_q >= uart_lin_rx_pkg::BRK_RX_MIN;
  assign data_par   = ^(mode_i.char_len8 ? shift_q : {1'b0, shift_q[6:0]});

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= '0;
      bit_idx_q  <= '0;
      low_cnt_q  <= '0;
    end else if (!rx_on) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= '0;
      bit_idx_q  <= '0;
      low_cnt_q  <= '0;
    end else begin
      if (rx_state_q == RX_IDLE || start_tick || bit_tick) begin
        rx_cnt_q <= '0;
      end else begin
        rx_cnt_q <= rx_cnt_q + 9'h001;
      end
      case (rx_state_q)
        RX_IDLE: begin
          if (filt_prev_q && !filt_q) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (start_tick) begin
            if (filt_q) begin
              rx_state_q <= RX_IDLE;
            end else if (brk_rx_en_q) begin
              rx_state_q <= RX_BREAK;
              low_cnt_q  <= 5'h01;
            end else begin
              rx_state_q <= RX_DATA;
              bit_idx_q  <= '0;
            end
          end
        end
        RX_DATA: begin
          if (bit_tick) begin
            bit_idx_q <= bit_idx_q + 3'h1;
            if (bit_idx_q == (mode_i.char_len8 ? 3'h7 : 3'h6)) begin
              rx_state_q <= (mode_i.parity_mode == uart_lin_rx_pkg::PAR_NONE)
                            ? RX_STOP : RX_PARITY;
            end
          end
        end
        RX_PARITY: begin
          if (bit_tick) begin
            rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (bit_tick) begin
            rx_state_q <= RX_IDLE;
          end
        end
        RX_BREAK: begin
          if (bit_tick) begin
            if (filt_q) begin
              rx_state_q <= RX_IDLE;
            end else if (low_cnt_q != uart_lin_rx_pkg::BRK_CNT_MAX) begin
              low_cnt_q <= low_cnt_q + 5'h01;
            end
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // data and parity capture
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q   <= '0;
      par_bit_q <= 1'b0;
    end else begin
      if (start_tick) begin
        shift_q <= '0;
      end else if (rx_state_q == RX_DATA && bit_tick) begin
        shift_q[bit_idx_q] <= filt_q;
      end
      if (rx_state_q == RX_PARITY && bit_tick) begin
        par_bit_q <= filt_q;
      end
    end
  end

  // error causes at the stop position
  always_comb begin
    new_err = '0;
    if (frame_end) begin
      new_err.framing = !filt_q;
      new_err.overrun = !fifo_in_ready;
      case (mode_i.parity_mode)
        uart_lin_rx_pkg::PAR_ODD:  new_err.parity = !(data_par ^ par_bit_q);
        uart_lin_rx_pkg::PAR_EVEN: new_err.parity = data_par ^ par_bit_q;
        default:                   new_err.parity = 1'b0;
      endcase
    end
  end

  assign fifo_push = frame_end && fifo_in_ready;

  // error status, cleared by a read; a new error wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_error_status_reg_o <= '0;
    end else if (rx_status_read_i) begin
      rx_error_status_reg_o <= new_err;
    end else begin
      rx_error_status_reg_o <= rx_error_status_reg_o | new_err;
    end
  end

  // receive interrupts
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_complete_irq_o <= 1'b0;
      rx_error_irq_o    <= 1'b0;
    end else begin
      rx_complete_irq_o <= (frame_end && (new_err == '0
                            || mode_i.error_irq_merge_bit))
                           || (brk_end && brk_ok);
      rx_error_irq_o    <= frame_end && new_err != '0
                           && !mode_i.error_irq_merge_bit;
    end
  end

  // break receive enable and flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brk_rx_en_q     <= 1'b0;
      break_rx_flag_o <= 1'b0;
    end else begin
      if (!rx_on) begin
        brk_rx_en_q <= 1'b0;
      end else if (brk_end && brk_ok) begin
        brk_rx_en_q <= 1'b0;
      end else if (break_rx_enable_set_i) begin
        brk_rx_en_q <= 1'b1;
      end
      if (!rx_on || (brk_end && brk_ok)) begin
        break_rx_flag_o <= 1'b0;
      end else if (rx_state_q == RX_BREAK && low_cnt_q >=
                   uart_lin_rx_pkg::BRK_RX_MIN) begin
        break_rx_flag_o <= 1'b1;
      end
    end
  end

  assign break_rx_enable_o = brk_rx_en_q;

  // receive queue and receive buffer stage
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       fifo_pop;

  assign fifo_pop = fifo_out_valid && (!rx_buffer_valid_o || rx_buffer_read_i);

  rx_fifo #(
    .WIDTH (uart_lin_rx_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (shift_q),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      receive_buffer_reg_o <= uart_lin_rx_pkg::RX_BUF_RESET;
      rx_buffer_valid_o    <= 1'b0;
    end else if (fifo_pop) begin
      receive_buffer_reg_o <= fifo_out_data;
      rx_buffer_valid_o    <= 1'b1;
    end else if (rx_buffer_read_i) begin
      rx_buffer_valid_o    <= 1'b0;
    end
  end

  // break transmit
  logic          tx_on;
  logic [CW-1:0] tx_cnt_q;
  logic [4:0]    tx_bits_q;
  logic [4:0]    brk_len;
  logic          tx_brk_last;
  logic          trig_d;

  assign tx_on       = mode_i.port_power_on && mode_i.transmit_enable_bit;
  assign brk_len     = uart_lin_rx_pkg::BRK_TX_BASE
                       + {2'b00, mode_i.break_length_field};
  assign tx_brk_last = break_tx_trigger_o && tx_cnt_q == full_lim
                       && tx_bits_q == brk_len - 5'h01;
  assign trig_d      = tx_on && !tx_brk_last
                       && (break_tx_trigger_o || break_tx_set_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_cnt_q  <= '0;
      tx_bits_q <= '0;
    end else if (!break_tx_trigger_o) begin
      tx_cnt_q  <= '0;
      tx_bits_q <= '0;
    end else if (tx_cnt_q == full_lim) begin
      tx_cnt_q  <= '0;
      tx_bits_q <= tx_bits_q + 5'h01;
    end else begin
      tx_cnt_q  <= tx_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      break_tx_trigger_o <= 1'b0;
      serial_out_pin_o   <= 1'b0;
      tx_complete_irq_o  <= 1'b0;
    end else begin
      break_tx_trigger_o <= trig_d;
      serial_out_pin_o   <= mode_i.port_power_on && !trig_d;
      tx_complete_irq_o  <= tx_brk_last && tx_on;
    end
  end

  filter_lag_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (samp0_q == samp1_q) |=> filt_q == $past(samp0_q))
    else $error("filter did not follow two agreeing samples");

  rx_hold_clr_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !rx_on |=> rx_cnt_q == '0 && rx_state_q == RX_IDLE)
    else $error("receive counter not held while disabled");

  status_clear_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rx_status_read_i && new_err == '0 |=> rx_error_status_reg_o == '0)
    else $error("error status not cleared by read");

  err_irq_cause_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rx_error_irq_o |-> rx_error_status_reg_o != '0
                         && !$past(mode_i.error_irq_merge_bit))
    else $error("error irq without a flag or while merged");

  overrun_drop_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      frame_end && !fifo_in_ready |-> !fifo_push
                                      ##1 rx_error_status_reg_o.overrun)
    else $error("overrun frame stored or not flagged");

  brk_no_load_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rx_state_q == RX_BREAK && !rx_status_read_i |-> !fifo_push
        ##1 rx_error_status_reg_o == $past(rx_error_status_reg_o))
    else $error("break reception loaded data or flagged an error");

  brk_short_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      brk_end && !brk_ok |=> !rx_complete_irq_o && brk_rx_en_q)
    else $error("short break raised irq or dropped enable");

  brk_tx_low_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      break_tx_trigger_o |-> !serial_out_pin_o)
    else $error("transmit pin high during break");

  brk_tx_end_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(break_tx_trigger_o) && $past(tx_on) |-> tx_complete_irq_o)
    else $error("break end without transmit complete");

endmodule // uart_lin_receive_and_break

/* File: uart_lin_rx_pkg.sv */
/*
  shared constants and carrier types of the lin-capable serial receive path.
  assumes one clock, the base clock, drives every user of this package.
*/
package uart_lin_rx_pkg;

  localparam int DATA_W         = 8;
  localparam int DIV_W          = 8;
  localparam int CNT_W          = DIV_W + 1;
  localparam int FIFO_DEPTH     = 4;

  localparam logic [7:0] DIV_MIN      = 8'h04;
  localparam logic [7:0] RX_BUF_RESET = 8'hff;

  // break field lengths in bit times
  localparam logic [4:0] BRK_TX_BASE  = 5'h0d;
  localparam logic [4:0] BRK_RX_MIN   = 5'h0b;
  localparam logic [4:0] BRK_CNT_MAX  = 5'h1f;

  // error status field positions
  localparam int ERR_OVERRUN_BIT = 0;
  localparam int ERR_PARITY_BIT  = 1;
  localparam int ERR_FRAMING_BIT = 2;

  // parity mode encodings
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  typedef struct packed {
    logic framing;
    logic parity;
    logic overrun;
  } rx_err_t;

  typedef struct packed {
    logic       port_power_on;
    logic       transmit_enable_bit;
    logic       receive_enable_bit;
    logic       error_irq_merge_bit;
    logic       char_len8;
    logic [1:0] parity_mode;
    logic [7:0] baud_divisor_field;
    logic [2:0] break_length_field;
  } serial_mode_t;

endpackage

/* File: rx_fifo.sv */
/*
  small first-in first-out store with valid and ready on both sides.
  assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("rx_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr_q ^ rd_ptr_q) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_ptr_q != rd_ptr_q;
  assign out_data_o  = mem_q[rd_ptr_q[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  full_block_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !in_ready_o && !pop |=> !in_ready_o)
    else $error("fifo left full without a pop");

endmodule // rx_fifo

/* File: serial_node_model.sv */
/*
  model of the remote serial node that drives the receive pin.
  assumes the same base clock as the block and a shared divisor value.
*/
`timescale 1ns/1ns
module serial_node_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] div_i,
  output logic            serial_in_pin_o
);
  initial serial_in_pin_o = 1'b1;

  // hold a level for a number of bit times of 2k base clocks
  task automatic hold(input logic lvl, input int bits);
    repeat (bits * 2 * int'(div_i)) begin
      @(posedge clk_i);
      serial_in_pin_o <= lvl;
    end
  endtask

  // start, eight data bits lsb first, optional parity, one stop
  task automatic send_frame(input logic [7:0] d, input logic par_on,
                            input logic par, input logic stp);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold(d[i], 1);
    end
    if (par_on) begin
      hold(par, 1);
    end
    hold(stp, 1);
    hold(1'b1, 1);
  endtask

  // low period of a break field followed by idle
  task automatic send_break(input int bits);
    hold(1'b0, bits);
    hold(1'b1, 2);
  endtask

  // single base clock low pulse
  task automatic glitch();
    @(posedge clk_i);
    serial_in_pin_o <= 1'b0;
    @(posedge clk_i);
    serial_in_pin_o <= 1'b1;
    hold(1'b1, 3);
  endtask
endmodule // serial_node_model

/* File: tb_uart_lin_receive_and_break.sv */
/*
  self-checking bench of the lin receive and break block.
  assumes the node model in serial_node_model.sv and a divisor of 4.
*/
`timescale 1ns/1ns
module tb_uart_lin_receive_and_break;
  logic                          clk_i = 1'b0;
  logic                          rst_n_i = 1'b0;
  uart_lin_rx_pkg::serial_mode_t mode;
  logic                          brk_tx = 1'b0;
  logic                          brk_rx = 1'b0;
  logic                          st_rd = 1'b0;
  logic                          buf_rd = 1'b0;
  logic                          rx_pin;
  logic                          tx_pin;
  logic [7:0]                    rx_buf;
  logic                          rx_valid;
  uart_lin_rx_pkg::rx_err_t      rx_status;
  logic                          irq_cpl;
  logic                          irq_err;
  logic                          irq_tx;
  logic                          trig;
  logic                          brk_en;
  logic                          brk_flag;
  logic [7:0]                    v;
  int                            error_cnt = 0;
  int                            checked = 0;
  int                            n_cpl = 0;
  int                            n_err = 0;
  int                            n_flag = 0;
  int                            c;
  int                            f;

  always #50 clk_i = ~clk_i;

  uart_lin_receive_and_break i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode),
    .break_tx_set_i(brk_tx), .break_rx_enable_set_i(brk_rx),
    .rx_status_read_i(st_rd), .rx_buffer_read_i(buf_rd),
    .serial_in_pin_i(rx_pin), .serial_out_pin_o(tx_pin),
    .receive_buffer_reg_o(rx_buf), .rx_buffer_valid_o(rx_valid),
    .rx_error_status_reg_o(rx_status), .rx_complete_irq_o(irq_cpl),
    .rx_error_irq_o(irq_err), .tx_complete_irq_o(irq_tx),
    .break_tx_trigger_o(trig), .break_rx_enable_o(brk_en),
    .break_rx_flag_o(brk_flag)
  );

  serial_node_model i_node (
    .clk_i(clk_i), .div_i(mode.baud_divisor_field),
    .serial_in_pin_o(rx_pin)
  );

  // pulse counters, sampled away from the launching edge
  always @(negedge clk_i) begin
    if (irq_cpl === 1'b1) n_cpl++;
    if (irq_err === 1'b1) n_err++;
    if (brk_flag === 1'b1) n_flag++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic read_status(output logic [2:0] s);
    s = rx_status;
    @(posedge clk_i);
    st_rd <= 1'b1;
    @(posedge clk_i);
    st_rd <= 1'b0;
    wait_cyc(1);
  endtask

  task automatic read_buffer(output logic [7:0] d);
    d = rx_buf;
    @(posedge clk_i);
    buf_rd <= 1'b1;
    @(posedge clk_i);
    buf_rd <= 1'b0;
    wait_cyc(1);
  endtask

  // one frame with even parity, then irq counts and status compared
  task automatic rx_case(input logic [7:0] d, input logic bad,
                         input logic stp, input int ec, input int ee,
                         input logic [2:0] es);
    int         c0;
    int         e0;
    logic [2:0] s;
    c0 = n_cpl;
    e0 = n_err;
    i_node.send_frame(d, 1'b1, bad ^ (^d), stp);
    wait_cyc(4);
    check(8'(n_cpl - c0), 8'(ec));
    check(8'(n_err - e0), 8'(ee));
    read_status(s);
    check(8'(s), 8'(es));
    check(8'(rx_status), 8'h00);
  endtask

  // break of (13 + code) bit times, measured in base clocks
  task automatic break_tx(input logic [2:0] code);
    int n;
    @(posedge clk_i);
    mode.break_length_field <= code;
    brk_tx <= 1'b1;
    @(posedge clk_i);
    brk_tx <= 1'b0;
    #1;
    check(8'(trig), 8'h01);
    n = 0;
    while (tx_pin === 1'b0 && n < 400) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(8'(n), 8'((13 + int'(code)) * 8));
    check(8'(irq_tx), 8'h01);
    check(8'(trig), 8'h00);
  endtask

  initial begin
    #3_000_000;
    error_cnt++;
    finish_test();
  end

  initial begin
    mode = '0;
    mode.char_len8 = 1'b1;
    mode.parity_mode = uart_lin_rx_pkg::PAR_EVEN;
    mode.baud_divisor_field = 8'h04;
    repeat (4) @(posedge clk_i);
    check(rx_buf, 8'hff);
    check(8'(tx_pin), 8'h00);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    mode.port_power_on <= 1'b1;
    wait_cyc(2);
    check(8'(tx_pin), 8'h01);
    rx_case(8'h55, 1'b0, 1'b1, 0, 0, 3'h0);
    @(posedge clk_i);
    mode.receive_enable_bit <= 1'b1;
    mode.transmit_enable_bit <= 1'b1;
    wait_cyc(4);
    rx_case(8'h55, 1'b0, 1'b1, 1, 0, 3'h0);
    read_buffer(v);
    check(v, 8'h55);
    c = n_cpl + n_err;
    i_node.glitch();
    check(8'(n_cpl + n_err - c), 8'h00);
    rx_case(8'ha3, 1'b1, 1'b1, 0, 1, 3'h2);
    read_buffer(v);
    check(v, 8'ha3);
    rx_case(8'h3c, 1'b0, 1'b0, 0, 1, 3'h4);
    read_buffer(v);
    check(v, 8'h3c);
    @(posedge clk_i);
    mode.error_irq_merge_bit <= 1'b1;
    rx_case(8'h0f, 1'b1, 1'b1, 1, 0, 3'h2);
    read_buffer(v);
    check(v, 8'h0f);
    @(posedge clk_i);
    mode.error_irq_merge_bit <= 1'b0;
    for (int i = 1; i < 6; i++) begin
      v = 8'(i);
      i_node.send_frame(v, 1'b1, ^v, 1'b1);
    end
    rx_case(8'h06, 1'b0, 1'b1, 0, 1, 3'h1);
    check(rx_buf, 8'h01);
    for (int i = 1; i < 6; i++) begin
      read_buffer(v);
      check(v, 8'(i));
    end
    check(8'(rx_valid), 8'h00);
    // odd and zero parity; the bad argument flips the even parity bit
    @(posedge clk_i);
    mode.parity_mode <= uart_lin_rx_pkg::PAR_ODD;
    rx_case(8'h5a, 1'b0, 1'b1, 0, 1, 3'h2);
    rx_case(8'h5a, 1'b1, 1'b1, 1, 0, 3'h0);
    @(posedge clk_i);
    mode.parity_mode <= uart_lin_rx_pkg::PAR_ZERO;
    rx_case(8'h5a, 1'b1, 1'b1, 1, 0, 3'h0);
    // seven bits, no parity: data bit 7 of the node lands as the stop bit
    @(posedge clk_i);
    mode.parity_mode <= uart_lin_rx_pkg::PAR_NONE;
    mode.char_len8 <= 1'b0;
    c = n_cpl;
    i_node.send_frame(8'hb3, 1'b0, 1'b0, 1'b1);
    wait_cyc(4);
    check(8'(n_cpl - c), 8'h01);
    check(8'(rx_status), 8'h00);
    for (int i = 0; i < 4; i++) begin
      read_buffer(v);
      check(v, (i < 3) ? 8'h5a : 8'h33);
    end
    @(posedge clk_i);
    mode.char_len8 <= 1'b1;
    @(posedge clk_i);
    brk_rx <= 1'b1;
    @(posedge clk_i);
    brk_rx <= 1'b0;
    wait_cyc(2);
    check(8'(brk_en), 8'h01);
    c = n_cpl;
    f = n_flag;
    i_node.send_break(10);
    check(8'(n_cpl - c), 8'h00);
    check(8'(n_flag - f), 8'h00);
    check(8'(brk_en), 8'h01);
    i_node.send_break(11);
    check(8'(n_cpl - c), 8'h01);
    check(8'(n_flag > f), 8'h01);
    check(8'(brk_flag), 8'h00);
    check(8'(brk_en), 8'h00);
    check(8'(rx_status), 8'h00);
    check(8'(rx_valid), 8'h00);
    break_tx(3'h0);
    break_tx(3'h7);
    finish_test();
  end
endmodule // tb_uart_lin_receive_and_break
